// ==== verilog/adc_ctrl_pkg.sv ====
// Purpose: shared constants for the converter control and readout block
// Assumes: core_clk at 100 MHz
// Notes: bit-cycle length stands in for the internal conversion clock
package adc_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RES_BITS = 12;
    localparam int SHORT_BITS = 8;
    // internal conversion clock period, in ns
    localparam int BIT_PERIOD_NS = 100;
    localparam int BIT_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_CNT_LAST = 4'(BIT_CYCLES - 1);
    // input acquisition, in internal clock periods
    localparam logic [3:0] ACQ_PERIODS = 4'h2;
    // lowest three bits and bit 3 after a short conversion
    localparam logic [3:0] SHORT_TAIL = 4'h8;
    localparam logic [11:0] SAR_RESET = 12'h000;
    localparam logic [11:0] MSB_TRIAL = 12'h800;
    // the last bit index decided in each length
    localparam logic [3:0] LAST_BIT_LONG = 4'h0;
    localparam logic [3:0] LAST_BIT_SHORT = 4'h4;
    localparam logic [3:0] FIRST_BIT = 4'hb;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_DONE
    } conv_state_t;
endpackage

// ==== verilog/in_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to core_clk
// Notes: reset value is given per instance
`timescale 1ns/1ps
`default_nettype none
module in_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule
`default_nettype wire

// ==== verilog/bit_timer.sv ====
// Purpose: internal conversion clock as a tick every bit period
// Assumes: run is held high for the whole conversion
// Notes: stopping run clears the count, so each start is aligned
`timescale 1ns/1ps
`default_nettype none
module bit_timer
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    output logic tick
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    always_comb
    begin
        cnt_next = 4'h0;
        if (run && cnt_reg != BIT_CNT_LAST)
        begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick = run && (cnt_reg == BIT_CNT_LAST);
endmodule
`default_nettype wire

// ==== verilog/adc_ctrl.sv ====
// Purpose: start, length, busy status and three-state readout of a
//          12-bit successive-approximation converter
// Assumes: pins are asynchronous; the comparator result is a live level
// Notes: data pins are split into output value and per-bit enable
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control pins
    input wire logic chip_enable,
    input wire logic chip_select_n,
    input wire logic read_convert,
    input wire logic word_width_sel,
    input wire logic byte_select,
    // comparator: high when trial code is not above the input
    input wire logic cmp_keep,
    // analog front end controls
    output logic sample_hold,
    output logic [11:0] capacitive_dac,
    // status and data
    output logic busy_status,
    output logic [11:0] data_out_bus,
    output logic [11:0] data_out_oe
);
    logic [4:0] pins_s;
    logic ce_s;
    logic cs_n_s;
    logic rc_s;
    logic width_s;
    logic bsel_s;
    logic cmp_s;
    logic tick;

    // synchronise all pins together so they see one delay
    in_sync #(
        .W(5),
        .RST_VAL(5'h02)
    ) u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d({chip_enable, chip_select_n, read_convert, word_width_sel,
            byte_select}),
        .q(pins_s)
    );
    assign ce_s = pins_s[4];
    assign cs_n_s = pins_s[3];
    assign rc_s = pins_s[2];
    assign width_s = pins_s[1];
    assign bsel_s = pins_s[0];

    in_sync #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_cmp_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d(cmp_keep),
        .q(cmp_s)
    );

    conv_state_t state_reg;
    conv_state_t state_next;
    logic start_prev_reg;
    logic start_prev_next;
    logic short_reg;
    logic short_next;
    logic [11:0] sar_reg;
    logic [11:0] sar_next;
    logic [11:0] result_reg;
    logic [11:0] result_next;
    logic [3:0] bit_idx_reg;
    logic [3:0] bit_idx_next;
    logic [3:0] acq_reg;
    logic [3:0] acq_next;
    logic busy_reg;
    logic busy_next;
    logic hold_reg;
    logic hold_next;
    logic [11:0] dout_reg;
    logic [11:0] dout_next;
    logic [11:0] oe_reg;
    logic [11:0] oe_next;
    logic start_cond;
    logic start_edge;
    logic clk_run;
    logic [11:0] bit_mask;

    // one-hot mask of the bit under trial
    function automatic logic [11:0] bit_onehot(input logic [3:0] idx);
        bit_onehot = MSB_TRIAL >> (FIRST_BIT - idx);
    endfunction

    assign start_cond = ce_s && !cs_n_s && !rc_s;
    assign start_edge = start_cond && !start_prev_reg;
    assign clk_run = (state_reg == ST_ACQ) || (state_reg == ST_CONV);
    assign bit_mask = bit_onehot(bit_idx_reg);

    bit_timer u_bit_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(clk_run),
        .tick(tick)
    );

    // conversion sequencing
    always_comb
    begin
        state_next = state_reg;
        start_prev_next = start_cond;
        short_next = short_reg;
        sar_next = sar_reg;
        result_next = result_reg;
        bit_idx_next = bit_idx_reg;
        acq_next = acq_reg;
        busy_next = busy_reg;
        hold_next = hold_reg;
        if (start_edge)
        begin
            short_next = bsel_s;
        end
        case (state_reg)
            ST_IDLE:
            begin
                if (start_edge)
                begin
                    state_next = ST_ACQ;
                    sar_next = SAR_RESET;
                    acq_next = 4'h0;
                    busy_next = 1'b1;
                    hold_next = 1'b0;
                end
            end
            ST_ACQ:
            begin
                // starts here are ignored apart from the length latch
                if (tick)
                begin
                    acq_next = acq_reg + 4'h1;
                    if (acq_reg + 4'h1 == ACQ_PERIODS)
                    begin
                        state_next = ST_CONV;
                        hold_next = 1'b1;
                        bit_idx_next = FIRST_BIT;
                        sar_next = MSB_TRIAL;
                    end
                end
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    // clear the trial bit if the comparator rejects it
                    sar_next = cmp_s ? sar_reg : (sar_reg & ~bit_mask);
                    if (bit_idx_reg == (short_reg ? LAST_BIT_SHORT
                        : LAST_BIT_LONG))
                    begin
                        state_next = ST_DONE;
                    end
                    else
                    begin
                        bit_idx_next = bit_idx_reg - 4'h1;
                        sar_next = sar_next | bit_onehot(bit_idx_reg - 4'h1);
                    end
                end
            end
            ST_DONE:
            begin
                // clock already stopped; latch result and drop busy on the same edge
                result_next = short_reg ? {sar_reg[11:4], SHORT_TAIL}
                    : sar_reg;
                busy_next = 1'b0;
                hold_next = 1'b0;
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            start_prev_reg <= 1'b0;
            short_reg <= 1'b0;
            sar_reg <= SAR_RESET;
            result_reg <= SAR_RESET;
            bit_idx_reg <= FIRST_BIT;
            acq_reg <= 4'h0;
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            start_prev_reg <= start_prev_next;
            short_reg <= short_next;
            sar_reg <= sar_next;
            result_reg <= result_next;
            bit_idx_reg <= bit_idx_next;
            acq_reg <= acq_next;
            busy_reg <= busy_next;
            hold_reg <= hold_next;
        end
    end

    // readout enables
    logic read_ok;
    logic [11:0] oe_want;

    always_comb
    begin
        read_ok = rc_s && !busy_reg && !busy_next && ce_s
            && !cs_n_s;
        oe_want = 12'h000;
        dout_next = result_reg;
        if (read_ok)
        begin
            if (width_s)
            begin
                oe_want = 12'hfff;
            end
            else if (!bsel_s)
            begin
                oe_want = 12'hff0;
            end
            else
            begin
                oe_want = 12'h0ff;
                dout_next = {result_reg[11:8], 4'h0, result_reg[3:0]};
            end
        end
        // drop any bit not wanted first; in byte mode add new bits only once
        // no other byte remains driven; a full-word read adds them to a driven byte at once
        if ((oe_reg & ~oe_want) != 12'h000)
        begin
            oe_next = oe_reg & oe_want;
        end
        else
        begin
            oe_next = oe_want;
        end
        if ((oe_next & ~oe_reg) != 12'h000 && !width_s && oe_reg != 12'h000
            && oe_next != oe_want)
        begin
            oe_next = 12'h000;
        end
        if (oe_want == 12'h0ff && oe_reg == 12'hff0)
        begin
            oe_next = 12'h000;
        end
        if (oe_want == 12'hff0 && oe_reg == 12'h0ff)
        begin
            oe_next = 12'h000;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dout_reg <= 12'h000;
            oe_reg <= 12'h000;
        end
        else
        begin
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    assign busy_status = busy_reg;
    assign sample_hold = hold_reg;
    assign capacitive_dac = sar_reg;
    assign data_out_bus = dout_reg;
    assign data_out_oe = oe_reg;
endmodule
`default_nettype wire

// ==== verif/analog_in_model.sv ====
// Purpose: comparator and input sampling seen by the converter
// Assumes: vin is the level applied at the analog input
// Notes: input tracks until sample_hold, then stays held
`timescale 1ns/1ps
`default_nettype none
module analog_in_model (
    // clock
    input wire logic core_clk,
    // converter side
    input wire logic sample_hold,
    input wire logic [11:0] capacitive_dac,
    // analog input
    input wire logic [11:0] vin,
    output logic cmp_keep
);
    logic [11:0] held_reg;
    always_ff @(posedge core_clk)
        if (!sample_hold)
            held_reg <= vin;
    // keep the trial bit while the trial code is not above the input
    assign cmp_keep = (capacitive_dac <= held_reg);
endmodule
`default_nettype wire

// ==== verif/adc_ctrl_assertions.sv ====
// Purpose: port checks for adc_ctrl
// Assumes: pins reach the outputs three edges after they change
// Notes: run_reg counts the cycles of one conversion
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_assertions
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // pins
    input wire logic chip_enable,
    input wire logic chip_select_n,
    input wire logic read_convert,
    input wire logic word_width_sel,
    input wire logic byte_select,
    input wire logic cmp_keep,
    // outputs
    input wire logic sample_hold,
    input wire logic [11:0] capacitive_dac,
    input wire logic busy_status,
    input wire logic [11:0] data_out_bus,
    input wire logic [11:0] data_out_oe
);
    logic [8:0] run_reg;
    logic [8:0] run_next;
    always_comb
        run_next = busy_status ? run_reg + 9'h001 : 9'h000;
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            run_reg <= 9'h000;
        else
            run_reg <= run_next;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_busy_no_out: assert property (
        busy_status |-> data_out_oe == 12'h000)
        else $error("outputs on while busy");
    a_oe_shape: assert property (
        data_out_oe inside {12'h000, 12'hfff, 12'hff0, 12'h0ff})
        else $error("bad enable pattern");
    a_low_byte_zero: assert property (
        data_out_oe == 12'h0ff |-> data_out_bus[7:4] == 4'h0)
        else $error("bits 7..4 not zero");
    a_break_make: assert property (
        $past(data_out_oe) inside {12'hff0, 12'h0ff} && $changed(data_out_oe)
        |-> data_out_oe inside {12'h000, 12'hfff})
        else $error("bytes swapped without gap");
    a_start_clear: assert property (
        $rose(busy_status) |-> capacitive_dac == SAR_RESET && !sample_hold)
        else $error("start did not clear");
    a_acq_time: assert property (
        $rose(busy_status) |-> !sample_hold [*8] ##[10:14] sample_hold)
        else $error("acquisition time wrong");
    a_msb_trial: assert property (
        $rose(sample_hold) |-> capacitive_dac == MSB_TRIAL)
        else $error("first trial not msb");
    a_conv_length: assert property (
        $fell(busy_status) |-> run_reg == 9'h065 || run_reg == 9'h08d)
        else $error("conversion length wrong");
    a_hold_to_end: assert property (
        $fell(sample_hold) |-> ##[0:2] !busy_status)
        else $error("conversion restarted");
    a_out_live: assert property (
        |data_out_oe |-> $past(read_convert, 3) && $past(chip_enable, 3)
        && !$past(chip_select_n, 3))
        else $error("outputs on without read");
    a_out_width: assert property (
        data_out_oe == 12'hfff |-> $past(word_width_sel, 3))
        else $error("full word without width");
    a_out_byte: assert property (
        data_out_oe[3:0] != data_out_oe[11:8] |-> !$past(word_width_sel, 3)
        && data_out_oe[3] == $past(byte_select, 3))
        else $error("wrong byte enabled");
    c_long: cover property ($fell(busy_status) && run_reg == 9'h08d);
    c_short: cover property ($fell(busy_status) && run_reg == 9'h065);
    c_high_byte: cover property (data_out_oe == 12'hff0);
    c_low_byte: cover property (data_out_oe == 12'h0ff);
endmodule
bind adc_ctrl adc_ctrl_assertions adc_ctrl_assertions_i (.core_clk,
    .sys_rst, .chip_enable, .chip_select_n, .read_convert, .word_width_sel,
    .byte_select, .cmp_keep, .sample_hold, .capacitive_dac, .busy_status,
    .data_out_bus, .data_out_oe);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: conversions and reads through the control pins
// Assumes: pins change on the falling edge
// Notes: every conversion run by check_conv gets a second start while busy
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_enable = 1'b1;
    logic chip_select_n = 1'b0;
    logic read_convert = 1'b1;
    logic word_width_sel = 1'b1;
    logic byte_select = 1'b0;
    logic [11:0] vin = 12'h000;
    logic [11:0] vals [4] = '{12'ha5c, 12'h3f1, 12'hfff, 12'h000};
    wire logic cmp_keep;
    wire logic sample_hold;
    wire logic busy_status;
    wire logic [11:0] capacitive_dac;
    wire logic [11:0] data_out_bus;
    wire logic [11:0] data_out_oe;
    int err_total = 0;
    int samples_checked = 0;
    int len;
    adc_ctrl adc_ctrl_i (.core_clk, .sys_rst, .chip_enable, .chip_select_n,
        .read_convert, .word_width_sel, .byte_select, .cmp_keep,
        .sample_hold, .capacitive_dac, .busy_status, .data_out_bus,
        .data_out_oe);
    analog_in_model analog_in_model_i (.core_clk, .sample_hold,
        .capacitive_dac, .vin, .cmp_keep);
    initial
        forever #5 core_clk = ~core_clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        i = 0;
        while (busy_status !== lvl && i < 300)
        begin
            @(negedge core_clk);
            i++;
        end
        chk({11'h000, busy_status}, {11'h000, lvl});
    endtask
    task automatic rd(input logic w, input logic bs, input logic [11:0] oe,
        input logic [11:0] d);
        @(negedge core_clk);
        word_width_sel = w;
        byte_select = bs;
        repeat (5) @(negedge core_clk);
        chk(data_out_oe, oe);
        chk(data_out_bus & oe, d & oe);
    endtask
    // last: 0 enable, 1 select, 2 read/convert, 3 all three at once
    task automatic check_conv(input logic bs, input int last,
        input logic bs2);
        time t0;
        logic [11:0] exp;
        @(negedge core_clk);
        word_width_sel = 1'b1;
        byte_select = bs;
        chip_enable = (last == 1) || (last == 2);
        chip_select_n = (last == 1) || (last == 3);
        read_convert = (last >= 2);
        repeat (6) @(negedge core_clk);
        chip_enable = 1'b1;
        chip_select_n = 1'b0;
        read_convert = 1'b0;
        wait_busy(1'b1);
        t0 = $time;
        read_convert = 1'b1;
        repeat (20) @(negedge core_clk);
        read_convert = 1'b0;
        byte_select = bs2;
        repeat (6) @(negedge core_clk);
        read_convert = 1'b1;
        wait_busy(1'b0);
        len = int'(($time - t0) / 10);
        chk(12'(len), bs2 ? 12'h065 : 12'h08d);
        exp = bs2 ? {vin[11:4], SHORT_TAIL} : vin;
        rd(1'b1, bs2, 12'hfff, exp);
        rd(1'b0, 1'b0, 12'hff0, exp);
        rd(1'b0, 1'b1, 12'h0ff, {exp[11:8], 4'h0, exp[3:0]});
    endtask
    initial
    begin
        #200000;
        err_total++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(data_out_oe, 12'h000);
        for (int k = 0; k < 8; k++)
        begin
            vin = vals[k % 4];
            check_conv(k[0], k % 4, k[0]);
        end
        vin = 12'h7c3;
        check_conv(1'b0, 2, 1'b1);
        chip_select_n = 1'b1;
        rd(1'b1, 1'b0, 12'h000, 12'h000);
        chip_select_n = 1'b0;
        chip_enable = 1'b0;
        rd(1'b1, 1'b0, 12'h000, 12'h000);
        chip_enable = 1'b1;
        read_convert = 1'b0;
        wait_busy(1'b1);
        sys_rst = 1'b1;
        @(negedge core_clk);
        chk({11'h000, busy_status}, 12'h000);
        sys_rst = 1'b0;
        read_convert = 1'b1;
        check_conv(1'b0, 2, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
